// ===== testbench/byte_multiplier_tb_top.sv
module byte_multiplier_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 1'b0, SRST = 1'b1, EXT_SET_EN = 1'b0, MEM_RD, BUSY, PROD_WE;
  logic [15:0] INSTR = 16'hffff;
  logic [7:0] ACCUM = 8'hc4, MEM_RDATA = 8'h00, PRODUCT_HIGH, PRODUCT_LOW;
  logic [3:0] BANK_SELECT = 4'h3, PHASE;
  logic [11:0] INDEX_BASE = 12'h120, MEM_ADDR;
  int fails = 0;
  int n_checks = 0;
  byte_multiplier u_byte_multiplier (.REF_CLK, .SRST, .INSTR, .ACCUM, .BANK_SELECT, .INDEX_BASE, .EXT_SET_EN,
    .MEM_RDATA, .MEM_ADDR, .MEM_RD, .PHASE, .BUSY, .PRODUCT_HIGH, .PRODUCT_LOW, .PROD_WE);
  initial forever #10 REF_CLK = ~REF_CLK;
  task summarize();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Opcode dropped after one cycle, so a stuck take shows up
  task op(input logic [15:0] i, input logic [7:0] m);
    int k;
    @(negedge REF_CLK) INSTR = i;
    MEM_RDATA = m;
    @(negedge REF_CLK) INSTR = 16'hffff;
    for (k = 0; PROD_WE !== 1'b1; k++) begin
      if (k == 8) begin
        $display("[FAIL] %0t no product", $time);
        fails++;
        summarize();
      end
      @(negedge REF_CLK);
    end
  endtask
  task fm(input logic [15:0] i, input logic [7:0] m, input logic [11:0] ea);
    logic [15:0] e;
    e = ACCUM * m;
    op(i, m);
    chk({PRODUCT_HIGH, PRODUCT_LOW}, e);
    chk({4'h0, MEM_ADDR}, {4'h0, ea});
  endtask
  task t_file();
    fm(16'h03b5, 8'hb5, 12'h3b5);
    fm(16'h025f, 8'hff, 12'h05f);
    fm(16'h0260, 8'h02, 12'hf60);
    EXT_SET_EN = 1'b1;
    fm(16'h025f, 8'h10, 12'h17f);
    fm(16'h0260, 8'h10, 12'hf60);
    EXT_SET_EN = 1'b0;
    $display("t_file done");
  endtask
  task t_imm();
    ACCUM = 8'he2;
    op(16'h0dc4, 8'h00);
    chk({PRODUCT_HIGH, PRODUCT_LOW}, 16'had08);
    op(16'h0d00, 8'hff);
    chk({PRODUCT_HIGH, PRODUCT_LOW}, 16'h0000);
    $display("t_imm done");
  endtask
  // Second opcode arrives mid-cycle and must wait for the Q4 take
  task t_b2b();
    @(negedge REF_CLK) INSTR = 16'h0d02;
    ACCUM = 8'he2;
    MEM_RDATA = 8'h03;
    @(negedge REF_CLK) INSTR = 16'h03b5;
    repeat (4) @(negedge REF_CLK);
    INSTR = 16'hffff;
    chk({PRODUCT_HIGH, PRODUCT_LOW}, 16'h01c4);
    chk({11'h000, PROD_WE, PHASE}, 16'h0011);
    repeat (4) @(negedge REF_CLK);
    chk({8'h00, PRODUCT_HIGH}, 16'h0002);
    chk({8'h00, PRODUCT_LOW}, 16'h00a6);
    chk({4'h0, MEM_ADDR}, 16'h03b5);
    chk({11'h000, PROD_WE, PHASE}, 16'h0010);
    $display("t_b2b done");
  endtask
  task t_refuse();
    INSTR = 16'h0400;
    repeat (6) @(negedge REF_CLK);
    chk({15'h0000, BUSY}, 16'h0000);
    INSTR = 16'hffff;
    $display("t_refuse done");
  endtask
  initial begin
    repeat (12) @(negedge REF_CLK);
    SRST = 1'b0;
    t_file();
    t_imm();
    t_b2b();
    t_refuse();
    summarize();
  end
endmodule // byte_multiplier_tb_top

// ===== testbench/mul_sva.sv
module mul_sva (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic [15:0] INSTR,
  input wire logic [3:0] PHASE,
  input wire logic BUSY,
  input wire logic MEM_RD,
  input wire logic PROD_WE,
  input wire logic [7:0] PRODUCT_HIGH,
  input wire logic [7:0] PRODUCT_LOW
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // Q4 counts as free, so back-to-back takes are legal
  wire free = PHASE == 4'h0 || PHASE == 4'h8;
  sequence s_walk;
    PHASE == 4'h2 ##1 PHASE == 4'h4 ##1 PHASE == 4'h8 ##1 PROD_WE;
  endsequence
  chk_walk_order: assert property (PHASE == 4'h1 |=> s_walk) else $error("walk");
  chk_take_file: assert property (free && INSTR[15:9] == 7'h01 |=> PHASE == 4'h1 && MEM_RD) else $error("file");
  chk_take_imm: assert property (free && INSTR[15:8] == 8'h0d |=> PHASE == 4'h1 && !MEM_RD) else $error("imm");
  chk_we_cause: assert property (PROD_WE |-> $past(PHASE) == 4'h8) else $error("we");
  chk_prod_hold: assert property (!PROD_WE |-> $stable({PRODUCT_HIGH, PRODUCT_LOW})) else $error("hold");
  chk_busy_phase: assert property (BUSY == (PHASE != 4'h0)) else $error("busy");
  chk_rd_first: assert property (MEM_RD |-> PHASE == 4'h1) else $error("rd");
  chk_ignore_mid: assert property (PHASE == 4'h2 || PHASE == 4'h4 |=> PHASE != 4'h1) else $error("mid");
endmodule // mul_sva
bind byte_multiplier mul_sva u_mul_sva (.REF_CLK, .SRST, .INSTR, .PHASE, .BUSY, .MEM_RD, .PROD_WE, .PRODUCT_HIGH,
  .PRODUCT_LOW);

// ===== verilog/byte_multiplier.v
`include "multiplier_regs.vh"
// Operation
// - Unsigned accumulator times memory byte
// - Full 16-bit result to product pair
// - High byte high, low byte low
// - Accumulator and source byte stay unchanged
// - No status flag changes on multiply
// - Decode 0000001a plus file address
// - Bank bit zero uses access bank
// - Bank bit one uses bank_select
// - Extended set, low address: indexed offset
// - Decode, read, compute, write phases
module byte_multiplier (
  input wire REF_CLK,
  input wire SRST,
  input wire [15:0] INSTR,
  input wire [7:0] ACCUM,
  input wire [3:0] BANK_SELECT,
  input wire [11:0] INDEX_BASE,
  input wire EXT_SET_EN,
  input wire [7:0] MEM_RDATA,
  output reg [11:0] MEM_ADDR,
  output reg MEM_RD,
  output reg [3:0] PHASE,
  output reg BUSY,
  output reg [7:0] PRODUCT_HIGH,
  output reg [7:0] PRODUCT_LOW,
  output reg PROD_WE
);
  // ****************************************
  // Phase sequencer
  // ****************************************
  localparam IDLE = 5'h01;
  localparam Q1 = 5'h02;
  localparam Q2 = 5'h04;
  localparam Q3 = 5'h08;
  localparam Q4 = 5'h10;
  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg is_file_r;
  reg is_file_nxt;
  reg [7:0] imm_r;
  reg [7:0] imm_nxt;
  reg [11:0] addr_nxt;
  reg rd_nxt;
  reg [3:0] phase_nxt;
  reg busy_nxt;
  reg [7:0] op_a_r;
  reg [7:0] op_a_nxt;
  reg [7:0] op_b_r;
  reg [7:0] op_b_nxt;
  reg [15:0] prod_r;
  reg [15:0] prod_nxt;
  reg [7:0] high_nxt;
  reg [7:0] low_nxt;
  reg we_nxt;
  wire [15:0] prod;
  wire take;
  wire f_bank;
  wire [7:0] f_addr;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Opcode tests are shared by the sequencer and the capture stage
  function dec_file;
    input [15:0] word;
    begin
      dec_file = (word[15:9] == `OPC_FILE_MUL);
    end
  endfunction

  function dec_imm;
    input [15:0] word;
    begin
      dec_imm = (word[15:8] == `OPC_IMM_MUL);
    end
  endfunction

  function dec_any;
    input [15:0] word;
    begin
      dec_any = dec_file(word) || dec_imm(word);
    end
  endfunction

  function [3:0] phase_code;
    input [4:0] st;
    begin
      case (st)
        Q1: phase_code = `PH_DECODE;
        Q2: phase_code = `PH_READ;
        Q3: phase_code = `PH_PROC;
        Q4: phase_code = `PH_WRITE;
        default: phase_code = 4'h0;
      endcase
    end
  endfunction

  // Address formation for the file operand
  function [11:0] op_address;
    input a;
    input [7:0] f;
    input [3:0] bank;
    input ext;
    input [11:0] base;
    begin
      if (a)
        op_address = {bank, f};
      else if (ext && (f <= `ILO_LIMIT))
        op_address = base + {4'h0, f};
      else if (f < `ACCESS_SPLIT)
        op_address = {4'h0, f};
      else
        op_address = {`ACCESS_HI_PAGE, f};
    end
  endfunction

  // ****************************************
  // Sequencer
  // ****************************************
  assign f_bank = INSTR[8];
  assign f_addr = INSTR[7:0];
  assign take = dec_any(INSTR);

  // Q4 also takes, so one word issues every four cycles
  always @* begin
    case (state_r)
      IDLE: state_nxt = take ? Q1 : IDLE;
      Q1: state_nxt = Q2;
      Q2: state_nxt = Q3;
      Q3: state_nxt = Q4;
      Q4: state_nxt = take ? Q1 : IDLE;
      default: state_nxt = IDLE;
    endcase
  end

  always @* begin
    phase_nxt = phase_code(state_nxt);
    busy_nxt = (state_nxt != IDLE);
  end

  // ****************************************
  // Capture and datapath
  // ****************************************
  // Operand capture happens only on a fresh take
  always @* begin
    is_file_nxt = is_file_r;
    imm_nxt = imm_r;
    addr_nxt = MEM_ADDR;
    rd_nxt = 1'b0;
    if (state_nxt == Q1) begin
      is_file_nxt = dec_file(INSTR);
      imm_nxt = f_addr;
      addr_nxt = op_address(f_bank, f_addr, BANK_SELECT, EXT_SET_EN, INDEX_BASE);
      rd_nxt = dec_file(INSTR);
    end
  end

  product_unit #(.W(8)) u_mul (
    .a(op_a_r),
    .b(op_b_r),
    .p(prod)
  );

  // Read only: no path writes the accumulator or the source byte
  always @* begin
    op_a_nxt = op_a_r;
    op_b_nxt = op_b_r;
    if (state_r == Q2) begin
      op_a_nxt = ACCUM;
      op_b_nxt = is_file_r ? MEM_RDATA : imm_r;
    end
  end

  always @* begin
    prod_nxt = prod_r;
    if (state_r == Q3)
      prod_nxt = prod;
  end

  // The pair strobe is the only write; no flag is touched
  always @* begin
    high_nxt = PRODUCT_HIGH;
    low_nxt = PRODUCT_LOW;
    we_nxt = 1'b0;
    if (state_r == Q4) begin
      high_nxt = prod_r[15:8];
      low_nxt = prod_r[7:0];
      we_nxt = 1'b1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge REF_CLK) begin
    if (SRST) begin
      state_r <= IDLE;
      PHASE <= 4'h0;
      BUSY <= 1'b0;
    end else begin
      state_r <= state_nxt;
      PHASE <= phase_nxt;
      BUSY <= busy_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (SRST) begin
      is_file_r <= 1'b0;
      imm_r <= 8'h00;
      MEM_ADDR <= 12'h000;
      MEM_RD <= 1'b0;
    end else begin
      is_file_r <= is_file_nxt;
      imm_r <= imm_nxt;
      MEM_ADDR <= addr_nxt;
      MEM_RD <= rd_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (SRST) begin
      op_a_r <= 8'h00;
      op_b_r <= 8'h00;
    end else begin
      op_a_r <= op_a_nxt;
      op_b_r <= op_b_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (SRST) begin
      prod_r <= 16'h0000;
    end else begin
      prod_r <= prod_nxt;
    end
  end

  // Product stays visible until the next write strobe
  always @(posedge REF_CLK) begin
    if (SRST) begin
      PRODUCT_HIGH <= 8'h00;
      PRODUCT_LOW <= 8'h00;
      PROD_WE <= 1'b0;
    end else begin
      PRODUCT_HIGH <= high_nxt;
      PRODUCT_LOW <= low_nxt;
      PROD_WE <= we_nxt;
    end
  end
endmodule // byte_multiplier

// ===== verilog/multiplier_regs.vh
`ifndef MULTIPLIER_REGS_VH
`define MULTIPLIER_REGS_VH
// ****************************************
// Opcodes, address limits and phases
// ****************************************
`define OPC_FILE_MUL 7'h01
`define OPC_IMM_MUL 8'h0d
`define ILO_LIMIT 8'h5f
`define ACCESS_SPLIT 8'h60
`define ACCESS_HI_PAGE 4'hf
`define PH_DECODE 4'h1
`define PH_READ 4'h2
`define PH_PROC 4'h4
`define PH_WRITE 4'h8
`endif

// ===== verilog/product_unit.v
`include "multiplier_regs.vh"
// ****************************************
// Unsigned 8x8 product
// ****************************************
module product_unit #(
  parameter W = 8
) (
  input wire [W-1:0] a,
  input wire [W-1:0] b,
  output wire [2*W-1:0] p
);
  // Zero extension only, no sign handling
  assign p = {{W{1'b0}}, a} * {{W{1'b0}}, b};
endmodule // product_unit
